// ### verilog/mtype_wc_path.sv
// memory-type write path: cache policy, combining store, bus sequencing
// assumes a chunk-wide core port and a single-beat handshake bus
`timescale 1ns/10ps
module mtype_wc_path
  import mtype_wc_pkg::*;
#(
  parameter int SETS    = CACHE_SETS,
  parameter int ENTRIES = WC_ENTRIES
)(
  // clock and reset
  input  wire logic              clk_sys_in,
  input  wire logic              srst_in,
  // core request
  input  wire logic              req_valid_in,
  output logic                   req_ready_out,
  input  wire logic              req_write_in,
  input  wire logic [ADDR_W-1:0] req_addr_in,
  input  wire logic [DATA_W-1:0] req_wdata_in,
  input  wire logic [7:0]        req_be_in,
  input  wire logic [2:0]        req_mtype_in,
  input  wire logic              req_spec_in,
  input  wire logic              range_wc_in,
  // serializing events: fences, identify, uncached, interrupt, lock
  input  wire logic              serialize_in,
  // core answer
  output logic                   rsp_valid_out,
  output logic [DATA_W-1:0]      rsp_rdata_out,
  // system bus
  output logic                   bus_valid_out,
  input  wire logic              bus_ready_in,
  output logic                   bus_write_out,
  output logic                   bus_burst_out,
  output logic                   bus_last_out,
  output logic                   bus_inval_out,
  output logic [ADDR_W-1:0]      bus_addr_out,
  output logic [DATA_W-1:0]      bus_wdata_out,
  output logic [7:0]             bus_be_out,
  input  wire logic              bus_rvalid_in,
  input  wire logic [DATA_W-1:0] bus_rdata_in
);

  localparam int IDX_W = $clog2(SETS);
  localparam int TAG_W = CADDR_W - IDX_W;
  localparam logic [CH_W-1:0] LAST_CH = CH_W'(LINE_CHUNKS - 1);

  // ==========================================================
  // policy decoding
  function automatic mem_type_e eff_type(input logic [2:0] t, input logic rwc);
    mem_type_e r;
    r = mem_type_e'(t);
    if (r == MT_OVERRIDABLE_UNCACHED)
      r = rwc ? MT_WRITE_COMBINING : MT_STRONG_UNCACHED;
    else if (!(r inside {MT_STRONG_UNCACHED, MT_WRITE_COMBINING, MT_WRITE_THROUGH,
                         MT_WRITE_PROTECTED, MT_WRITE_BACK}))
      r = MT_STRONG_UNCACHED;
    return r;
  endfunction : eff_type

  function automatic logic is_cached(input mem_type_e t);
    return t inside {MT_WRITE_THROUGH, MT_WRITE_BACK, MT_WRITE_PROTECTED};
  endfunction : is_cached

  // ==========================================================
  // state
  path_state_e           state;
  logic                  c_val   [SETS];
  logic                  c_dirty [SETS];
  logic [TAG_W-1:0]      c_tag   [SETS];
  logic [DATA_W-1:0]     c_data  [SETS];
  logic                  q_write;
  logic [CADDR_W-1:0]    q_ca;
  logic [DATA_W-1:0]     q_wdata;
  logic [7:0]            q_be;
  mem_type_e             q_type;
  logic [DATA_W-1:0]     rdata;
  logic                  ser_pend;
  logic [CH_W-1:0]       d_chunk;
  // port to the combining store, declared before any use
  wc_port_if             wc ();

  // ==========================================================
  // request decode
  mem_type_e             in_type;
  logic [CADDR_W-1:0]    in_ca;
  logic [IDX_W-1:0]      in_set, q_set;
  logic [TAG_W-1:0]      in_tag;
  logic                  in_hit, in_vdirty, in_uc, spec_block, drain_need, accept;
  logic                  wc_wr_req, hs, d_skip, d_step;

  assign in_type   = eff_type(req_mtype_in, range_wc_in);
  assign in_ca     = req_addr_in[ADDR_W-1:CHUNK_OFS_W];
  assign in_set    = in_ca[IDX_W-1:0];
  assign in_tag    = in_ca[CADDR_W-1:IDX_W];
  assign q_set     = q_ca[IDX_W-1:0];
  assign in_hit    = c_val[in_set] && c_tag[in_set] == in_tag;
  assign in_vdirty = c_val[in_set] && c_dirty[in_set];
  assign in_uc     = in_type == MT_STRONG_UNCACHED;
  assign wc_wr_req = in_type == MT_WRITE_COMBINING && req_write_in;

  // uncached access must wait until it is no longer speculative
  assign spec_block = in_uc && req_spec_in;

  // drain before accepting: serialization, full entry, uncached, no room
  assign drain_need = ser_pend || wc.full_any
                   || (req_valid_in && in_uc && wc.any_used)
                   || (req_valid_in && wc_wr_req && !wc.can_take);

  assign req_ready_out = state == S_IDLE && !drain_need && !spec_block;
  assign accept        = req_valid_in && req_ready_out;
  assign hs            = bus_valid_out && bus_ready_in;

  // ==========================================================
  // combining store
  wc_store #(
    .ENTRIES (ENTRIES)
  ) u_store (
    .clk_sys_in (clk_sys_in),
    .srst_in    (srst_in),
    .wc         (wc.store)
  );

  // combining writes bypass the cache entirely
  assign wc.wr    = accept && wc_wr_req;
  assign wc.addr  = req_addr_in;
  assign wc.wdata = req_wdata_in;
  assign wc.be    = req_be_in;
  assign wc.chunk = d_chunk;

  // partial eviction skips empty chunks; one beat per chunk at most
  assign d_skip = state == S_DRAIN && !wc.sel_full && wc.rd_be == BE_NONE;
  assign d_step = d_skip || (state == S_DRAIN && hs);
  assign wc.clr = d_step && d_chunk == LAST_CH;

  // serializing request held until every entry has drained
  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
      ser_pend <= 1'b0;
    else
      ser_pend <= serialize_in || (ser_pend && wc.any_used);
  end

  // chunk walk through the evicted entry, ascending order
  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
      d_chunk <= '0;
    else if (d_step)
      d_chunk <= d_chunk + 1'b1;
  end

  // ==========================================================
  // state machine
  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
      state <= S_IDLE;
    else
    begin
      unique case (state)
        S_IDLE:
          if (drain_need && !accept && !(req_valid_in && spec_block && !wc.any_used
                                          && !ser_pend && !wc.full_any))
            state <= wc.any_used ? S_DRAIN : S_IDLE;
          else if (accept)
          begin
            if (wc_wr_req)
              state <= S_DONE;
            else if (is_cached(in_type) && (!req_write_in || in_type == MT_WRITE_BACK))
              state <= in_hit ? S_DONE : (in_vdirty ? S_WBACK : S_FILL);
            else
              state <= S_BUS;
          end
        S_DRAIN: if (wc.clr) state <= S_IDLE;
        S_WBACK: if (hs) state <= S_FILL;
        S_FILL:  if (hs) state <= S_FWAIT;
        S_FWAIT: if (bus_rvalid_in) state <= S_DONE;
        S_BUS:   if (hs) state <= q_write ? S_DONE : S_BWAIT;
        S_BWAIT: if (bus_rvalid_in) state <= S_DONE;
        S_DONE:  state <= S_IDLE;
      endcase
    end
  end

  // request latch
  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      q_write <= 1'b0;
      q_ca    <= '0;
      q_wdata <= '0;
      q_be    <= BE_NONE;
      q_type  <= MT_STRONG_UNCACHED;
    end
    else if (accept)
    begin
      q_write <= req_write_in;
      q_ca    <= in_ca;
      q_wdata <= req_wdata_in;
      q_be    <= req_be_in;
      q_type  <= in_type;
    end
  end

  // ==========================================================
  // cache lines: hit updates, fills, invalidations
  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      for (int s = 0; s < SETS; s++)
      begin
        c_val[s]   <= 1'b0;
        c_dirty[s] <= 1'b0;
      end
    end
    else if (accept && in_hit && req_write_in)
    begin
      unique case (in_type)
        MT_WRITE_BACK:
        begin
          c_data[in_set]  <= merge_bytes(c_data[in_set], req_wdata_in, req_be_in);
          c_dirty[in_set] <= 1'b1;
        end
        MT_WRITE_THROUGH:
          c_data[in_set] <= merge_bytes(c_data[in_set], req_wdata_in, req_be_in);
        MT_WRITE_PROTECTED:
          c_val[in_set] <= 1'b0;
        default:
          c_val[in_set] <= c_val[in_set];
      endcase
    end
    else if (state == S_WBACK && hs)
      c_dirty[q_set] <= 1'b0;
    else if (state == S_FWAIT && bus_rvalid_in)
    begin
      c_val[q_set]   <= 1'b1;
      c_tag[q_set]   <= q_ca[CADDR_W-1:IDX_W];
      c_dirty[q_set] <= q_write;
      c_data[q_set]  <= q_write ? merge_bytes(bus_rdata_in, q_wdata, q_be) : bus_rdata_in;
    end
  end

  // read data for the answer
  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
      rdata <= '0;
    else if (accept && in_hit && !req_write_in && is_cached(in_type))
      rdata <= c_data[in_set];
    else if ((state == S_FWAIT || state == S_BWAIT) && bus_rvalid_in)
      rdata <= bus_rdata_in;
  end

  assign rsp_valid_out = state == S_DONE;
  assign rsp_rdata_out = rdata;

  // ==========================================================
  // bus drive
  always_comb
  begin
    bus_valid_out = 1'b0;
    bus_write_out = 1'b0;
    bus_burst_out = 1'b0;
    bus_last_out  = 1'b1;
    bus_inval_out = 1'b0;
    bus_addr_out  = {q_ca, {CHUNK_OFS_W{1'b0}}};
    bus_wdata_out = q_wdata;
    bus_be_out    = q_be;
    unique case (state)
      S_DRAIN:
      begin
        bus_valid_out = wc.sel_full || wc.rd_be != BE_NONE;
        bus_write_out = 1'b1;
        bus_burst_out = wc.sel_full;
        bus_last_out  = !wc.sel_full || d_chunk == LAST_CH;
        bus_addr_out  = {wc.sel_tag, d_chunk, {CHUNK_OFS_W{1'b0}}};
        bus_wdata_out = wc.rd_data;
        bus_be_out    = wc.sel_full ? BE_ALL : wc.rd_be;
      end
      S_WBACK:
      begin
        bus_valid_out = 1'b1;
        bus_write_out = 1'b1;
        bus_addr_out  = {c_tag[q_set], q_set, {CHUNK_OFS_W{1'b0}}};
        bus_wdata_out = c_data[q_set];
        bus_be_out    = BE_ALL;
      end
      S_FILL:
      begin
        bus_valid_out = 1'b1;
        bus_be_out    = BE_ALL;
      end
      S_BUS:
      begin
        bus_valid_out = 1'b1;
        bus_write_out = q_write;
        bus_inval_out = q_write && q_type == MT_WRITE_PROTECTED;
      end
      default:
        bus_valid_out = 1'b0;
    endcase
  end

  // ==========================================================
  // checks
  logic [CH_W:0] burst_beats, part_cnt;

  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in || wc.clr)
    begin
      burst_beats <= '0;
      part_cnt    <= '0;
    end
    else if (state == S_DRAIN && hs)
    begin
      if (bus_burst_out) burst_beats <= burst_beats + 1'b1;
      else part_cnt <= part_cnt + 1'b1;
    end
  end

  sequence s_accept_wb_hit;
    accept && req_write_in && in_type == MT_WRITE_BACK && in_hit;
  endsequence
  sequence s_accept_wt_write;
    accept && req_write_in && in_type == MT_WRITE_THROUGH;
  endsequence

  a_uc_not_spec: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    accept && in_uc |-> !req_spec_in) else $error("speculative uncached access taken");
  a_uc_not_filled: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    state == S_FWAIT |-> is_cached(q_type)) else $error("uncached type filled a line");
  a_wc_bypass: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    accept && wc_wr_req |=> state == S_DONE ##1 state == S_IDLE)
    else $error("combining write not held in store");
  a_wt_to_bus: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    s_accept_wt_write |=> state == S_BUS && bus_valid_out && bus_write_out)
    else $error("write-through write missed the bus");
  a_wb_in_cache: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    s_accept_wb_hit |=> state == S_DONE && !bus_valid_out)
    else $error("write-back hit went to bus");
  a_wp_invalidate: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    bus_valid_out && state == S_BUS && q_type == MT_WRITE_PROTECTED && q_write
    |-> bus_inval_out) else $error("protected write without invalidate");
  a_serial_drain: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    serialize_in |=> ser_pend && !req_ready_out)
    else $error("serializing event did not hold requests");
  a_burst_whole: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    hs && bus_burst_out && bus_last_out |-> burst_beats == CH_W'(LINE_CHUNKS - 1))
    else $error("burst length is not a whole line");
  a_partial_chunk: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    state == S_DRAIN && bus_valid_out && !bus_burst_out
    |-> bus_be_out != BE_NONE && bus_last_out && bus_be_out == wc.rd_be)
    else $error("partial write not one whole chunk");
  a_partial_bound: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    part_cnt <= (CH_W+1)'(LINE_CHUNKS)) else $error("too many partial writes");

endmodule : mtype_wc_path

// ### verilog/mtype_wc_pkg.sv
// shared constants, memory-type codes and states of the write path
// assumes one core clock; address, data and chunk widths derive from the constants below, byte enables and type and state codes are fixed widths
package mtype_wc_pkg;

  // ==========================================================
  // geometry
  localparam int ADDR_W      = 32;
  localparam int DATA_W      = 64;
  localparam int CHUNK_BYTES = 8;
  localparam int LINE_BYTES  = 64;
  localparam int LINE_CHUNKS = LINE_BYTES / CHUNK_BYTES;
  localparam int CHUNK_OFS_W = $clog2(CHUNK_BYTES);
  localparam int LINE_OFS_W  = $clog2(LINE_BYTES);
  localparam int CH_W        = $clog2(LINE_CHUNKS);
  localparam int LTAG_W      = ADDR_W - LINE_OFS_W;
  localparam int CADDR_W     = ADDR_W - CHUNK_OFS_W;
  localparam int WC_ENTRIES  = 4;
  localparam int CACHE_SETS  = 16;

  // ==========================================================
  // byte-enable patterns: no lanes and all lanes
  localparam logic [7:0] BE_NONE = 8'h00;
  localparam logic [7:0] BE_ALL  = 8'hFF;

  // ==========================================================
  // memory types carried by each access
  typedef enum logic [2:0] {
    MT_STRONG_UNCACHED      = 3'h0,
    MT_WRITE_COMBINING      = 3'h1,
    MT_WRITE_THROUGH        = 3'h4,
    MT_WRITE_PROTECTED      = 3'h5,
    MT_WRITE_BACK           = 3'h6,
    MT_OVERRIDABLE_UNCACHED = 3'h7
  } mem_type_e;

  // path states, gray along idle-fill-wait-done and bus-wait
  typedef enum logic [2:0] {
    S_IDLE  = 3'h0,
    S_FILL  = 3'h1,
    S_FWAIT = 3'h3,
    S_DONE  = 3'h2,
    S_BUS   = 3'h6,
    S_BWAIT = 3'h7,
    S_WBACK = 3'h5,
    S_DRAIN = 3'h4
  } path_state_e;

  // byte-lane merge of new data over old
  function automatic logic [DATA_W-1:0] merge_bytes(input logic [DATA_W-1:0] old_d,
                                                    input logic [DATA_W-1:0] new_d,
                                                    input logic [7:0]        be);
    logic [DATA_W-1:0] r;
    r = old_d;
    for (int b = 0; b < 8; b++)
      if (be[b])
        r[b*8 +: 8] = new_d[b*8 +: 8];
    return r;
  endfunction : merge_bytes

endpackage : mtype_wc_pkg

// ### verilog/wc_port_if.sv
// port between the write path control and the combining store
// assumes both ends share the core clock
`timescale 1ns/10ps
interface wc_port_if;
  import mtype_wc_pkg::*;
  logic                    wr;
  logic [ADDR_W-1:0]       addr;
  logic [DATA_W-1:0]       wdata;
  logic [7:0]              be;
  logic                    clr;
  logic [CH_W-1:0]         chunk;
  logic                    can_take;
  logic                    any_used;
  logic                    full_any;
  logic                    sel_full;
  logic [LTAG_W-1:0]       sel_tag;
  logic [DATA_W-1:0]       rd_data;
  logic [7:0]              rd_be;
  modport ctrl  (output wr, addr, wdata, be, clr, chunk,
                 input  can_take, any_used, full_any, sel_full, sel_tag, rd_data, rd_be);
  modport store (input  wr, addr, wdata, be, clr, chunk,
                 output can_take, any_used, full_any, sel_full, sel_tag, rd_data, rd_be);
endinterface : wc_port_if

// ### verilog/wc_store.sv
// write-combining store: line entries with per-byte valid flags
// assumes the controller never writes and clears in the same cycle
`timescale 1ns/10ps
module wc_store
  import mtype_wc_pkg::*;
#(
  parameter int ENTRIES = WC_ENTRIES
)(
  // clock and reset
  input  wire logic clk_sys_in,
  input  wire logic srst_in,
  // control side
  wc_port_if.store  wc
);

  // ==========================================================
  // storage
  logic [ENTRIES-1:0]                 used;
  logic [LTAG_W-1:0]                  tag  [ENTRIES];
  logic [LINE_CHUNKS-1:0][DATA_W-1:0] data [ENTRIES];
  logic [LINE_CHUNKS-1:0][7:0]        bval [ENTRIES];
  logic [LTAG_W-1:0]                  in_tag;
  logic [CH_W-1:0]                    in_ch;
  logic                               match_hit, free_hit, sel_hit;
  int                                 match_i, free_i, sel_i;

  assign in_tag = wc.addr[ADDR_W-1:LINE_OFS_W];
  assign in_ch  = wc.addr[LINE_OFS_W-1:CHUNK_OFS_W];

  // entry search: match, free, and eviction pick
  always_comb
  begin
    match_hit = 1'b0; free_hit = 1'b0; sel_hit = 1'b0;
    match_i = 0; free_i = 0; sel_i = 0;
    wc.any_used = 1'b0; wc.full_any = 1'b0;
    for (int i = ENTRIES - 1; i >= 0; i--)
    begin
      if (used[i] && tag[i] == in_tag) begin match_hit = 1'b1; match_i = i; end
      if (!used[i]) begin free_hit = 1'b1; free_i = i; end
      if (used[i]) begin wc.any_used = 1'b1; if (!sel_hit) sel_i = i; end
      if (used[i] && &bval[i]) begin wc.full_any = 1'b1; sel_hit = 1'b1; sel_i = i; end
    end
    wc.can_take = match_hit | free_hit;
  end

  // eviction read port
  assign wc.sel_full = &bval[sel_i];
  assign wc.sel_tag  = tag[sel_i];
  assign wc.rd_data  = data[sel_i][wc.chunk];
  assign wc.rd_be    = bval[sel_i][wc.chunk];

  // one entry filled at a time, repeated bytes overwrite
  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      for (int i = 0; i < ENTRIES; i++)
      begin
        used[i] <= 1'b0;
        bval[i] <= '0;
      end
    end
    else if (wc.wr && wc.can_take)
    begin
      if (match_hit)
      begin
        data[match_i][in_ch] <= merge_bytes(data[match_i][in_ch], wc.wdata, wc.be);
        bval[match_i][in_ch] <= bval[match_i][in_ch] | wc.be;
      end
      else
      begin
        used[free_i]        <= 1'b1;
        tag[free_i]         <= in_tag;
        bval[free_i]        <= '0;
        bval[free_i][in_ch] <= wc.be;
        data[free_i][in_ch] <= wc.wdata;
      end
    end
    else if (wc.clr)
    begin
      used[sel_i] <= 1'b0;
      bval[sel_i] <= '0;
    end
  end

  // ==========================================================
  // checks
  a_reset_empties: assert property (@(posedge clk_sys_in)
    srst_in |=> !wc.any_used) else $error("store not empty after reset");
  a_collapse_keeps: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    (wc.wr && match_hit) |=> $countones(used) == $past($countones(used)))
    else $error("rewrite of held line allocated a new entry");
  a_one_fill: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    wc.wr |=> $countones(used) <= $past($countones(used)) + 1)
    else $error("more than one entry filled at once");

endmodule : wc_store

// ### tb/mem_bus_model.sv
// bus and memory partner: paces ready, answers reads, counts write beats
// assumes the path's single-beat valid/ready bus on the core clock
`timescale 1ns/10ps
module mem_bus_model
  import mtype_wc_pkg::*;
(
  // clock, reset, pacing
  input  wire logic              clk_sys_in,
  input  wire logic              srst_in,
  input  wire logic              slow_in,
  // bus from the path
  input  wire logic              bus_valid_in,
  input  wire logic              bus_write_in,
  input  wire logic              bus_burst_in,
  input  wire logic [ADDR_W-1:0] bus_addr_in,
  input  wire logic [DATA_W-1:0] bus_wdata_in,
  input  wire logic [7:0]        bus_be_in,
  input  wire logic              bus_last_in,
  input  wire logic              bus_inval_in,
  output logic                   bus_ready_out,
  output logic                   bus_rvalid_out,
  output logic [DATA_W-1:0]      bus_rdata_out
);
  // ==========================================================
  // write beat record, kept across resets
  int                n_beats = 0;
  int                n_burst = 0;
  int                n_last = 0;
  logic              last_inval;
  logic [DATA_W-1:0] last_wdata;
  logic [7:0]        last_be;
  // ready pacing, read data one cycle after handshake, else toggling
  always @(posedge clk_sys_in)
  begin
    bus_ready_out  <= srst_in | ~slow_in | ~bus_ready_out;
    bus_rvalid_out <= bus_valid_in & bus_ready_out & ~bus_write_in;
    if (bus_valid_in & bus_ready_out & ~bus_write_in)
      bus_rdata_out <= {bus_addr_in, bus_addr_in};
    else
      bus_rdata_out <= srst_in ? 64'h0 : ~bus_rdata_out;
    if (bus_valid_in & bus_ready_out & bus_write_in)
    begin
      n_beats    <= n_beats + 1;
      n_burst    <= n_burst + int'(bus_burst_in);
      n_last     <= n_last + int'(bus_last_in);
      last_inval <= bus_inval_in;
      last_wdata <= bus_wdata_in;
      last_be    <= bus_be_in;
    end
  end
endmodule : mem_bus_model

// ### tb/tb.sv
// self-checking bench of the memory-type write path
// assumes the path and the bus model above, reset held 4 cycles
`timescale 1ns/10ps
module tb;
  import mtype_wc_pkg::*;
  // ==========================================================
  // stimulus and observed signals
  logic clk_sys_in, srst_in, req_valid_in, req_write_in, req_spec_in, range_wc_in;
  logic serialize_in, slow, req_ready_out, rsp_valid_out, bus_valid_out, bus_ready_in;
  logic bus_write_out, bus_burst_out, bus_last_out, bus_inval_out, bus_rvalid_in;
  logic [ADDR_W-1:0] req_addr_in, bus_addr_out;
  logic [DATA_W-1:0] req_wdata_in, rsp_rdata_out, bus_wdata_out, bus_rdata_in, rdata;
  logic [7:0]        req_be_in, bus_be_out;
  logic [2:0]        req_mtype_in;
  int                miscompares = 0, checks_done = 0, waited, b;
  // design and partner
  mtype_wc_path dut (.clk_sys_in, .srst_in, .req_valid_in, .req_ready_out, .req_write_in,
    .req_addr_in, .req_wdata_in, .req_be_in, .req_mtype_in, .req_spec_in, .range_wc_in,
    .serialize_in, .rsp_valid_out, .rsp_rdata_out, .bus_valid_out, .bus_ready_in,
    .bus_write_out, .bus_burst_out, .bus_last_out, .bus_inval_out, .bus_addr_out,
    .bus_wdata_out, .bus_be_out, .bus_rvalid_in, .bus_rdata_in);
  mem_bus_model mem (.clk_sys_in, .srst_in, .slow_in(slow), .bus_valid_in(bus_valid_out),
    .bus_write_in(bus_write_out), .bus_burst_in(bus_burst_out), .bus_addr_in(bus_addr_out),
    .bus_wdata_in(bus_wdata_out), .bus_be_in(bus_be_out), .bus_ready_out(bus_ready_in),
    .bus_last_in(bus_last_out), .bus_inval_in(bus_inval_out),
    .bus_rvalid_out(bus_rvalid_in), .bus_rdata_out(bus_rdata_in));
  // ==========================================================
  // verdict, compare, bounded wait
  task automatic close_out();
    if (miscompares == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : close_out
  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic tick();
    @(negedge clk_sys_in);
    waited++;
    if (waited > 400)
    begin
      miscompares++;
      close_out();
    end
  endtask : tick
  // one core request, held until taken, answer captured
  task automatic req(input logic w, input logic [31:0] a, input logic [63:0] d,
                     input logic [7:0] be, input logic [2:0] mt);
    @(posedge clk_sys_in);
    {req_valid_in, req_write_in, req_addr_in, req_wdata_in} <= {1'b1, w, a, d};
    {req_be_in, req_mtype_in} <= {be, mt};
    waited = 0;
    do tick(); while (req_ready_out !== 1'b1);
    @(posedge clk_sys_in);
    req_valid_in <= 1'b0;
    do tick(); while (rsp_valid_out !== 1'b1);
    rdata = rsp_rdata_out;
  endtask : req
  task automatic wait_beats(input int n);
    waited = 0;
    do tick(); while (mem.n_beats < n);
    repeat (20) @(negedge clk_sys_in);
  endtask : wait_beats
  // ==========================================================
  // scenarios
  task automatic sc_wb();
    b = mem.n_beats;
    req(1'b1, 32'h100, 64'h1122334455667788, 8'hFF, MT_WRITE_BACK);
    req(1'b1, 32'h100, 64'h99, 8'h01, MT_WRITE_BACK);
    req(1'b0, 32'h100, 64'h0, 8'hFF, MT_WRITE_BACK);
    chk("wb_hit_data", rdata, 64'h1122334455667799);
    chk("wb_no_write", mem.n_beats, b);
    req(1'b1, 32'h180, 64'h0, 8'h00, MT_WRITE_BACK);
    chk("wb_evict_cnt", mem.n_beats, b + 1);
    chk("wb_evict_data", mem.last_wdata, 64'h1122334455667799);
  endtask : sc_wb
  task automatic sc_wt_wp();
    b = mem.n_beats;
    req(1'b0, 32'h408, 64'h0, 8'hFF, MT_WRITE_THROUGH);
    chk("wt_fill", rdata, 64'h0000040800000408);
    req(1'b1, 32'h408, 64'h5A5A5A5A5A5A5A5A, 8'h0F, MT_WRITE_THROUGH);
    req(1'b0, 32'h408, 64'h0, 8'hFF, MT_WRITE_THROUGH);
    chk("wt_hit_data", rdata, 64'h000004085A5A5A5A);
    chk("wt_to_mem", mem.n_beats, b + 1);
    req(1'b1, 32'h408, 64'h0, 8'h01, MT_WRITE_PROTECTED);
    chk("wp_inval", mem.last_inval, 1'b1);
    chk("wp_beats", mem.n_beats, b + 2);
    req(1'b0, 32'h408, 64'h0, 8'hFF, MT_WRITE_PROTECTED);
    chk("wp_refill", rdata, 64'h0000040800000408);
  endtask : sc_wt_wp
  task automatic sc_uc(input logic [2:0] mt);
    @(posedge clk_sys_in);
    {req_valid_in, req_write_in, req_addr_in, req_spec_in} <= {2'b10, 32'h310, 1'b1};
    req_mtype_in <= mt;
    repeat (3) @(negedge clk_sys_in);
    chk("uc_spec_wait", req_ready_out, 1'b0);
    @(posedge clk_sys_in);
    {req_valid_in, req_spec_in} <= 2'b00;
    b = mem.n_beats;
    req(1'b1, 32'h300, 64'hC0DE0000C0DE0001, 8'h3C, mt);
    chk("uc_beat", mem.n_beats, b + 1);
    chk("uc_be", mem.last_be, 8'h3C);
    req(1'b0, 32'h308, 64'h0, 8'hFF, mt);
    chk("uc_read", rdata, 64'h0000030800000308);
  endtask : sc_uc
  task automatic sc_wc_part();
    b = mem.n_beats;
    req(1'b1, 32'h1010, 64'hAAAAAAAAAAAAAAAA, 8'hFF, MT_WRITE_COMBINING);
    req(1'b1, 32'h1010, 64'h5555555555555555, 8'h0F, MT_WRITE_COMBINING);
    chk("wc_held", mem.n_beats, b);
    @(posedge clk_sys_in);
    serialize_in <= 1'b1;
    @(posedge clk_sys_in);
    serialize_in <= 1'b0;
    wait_beats(b + 1);
    chk("wc_part_cnt", mem.n_beats, b + 1);
    chk("wc_collapse", mem.last_wdata, 64'hAAAAAAAA55555555);
    chk("wc_part_be", mem.last_be, 8'hFF);
  endtask : sc_wc_part
  task automatic sc_wc_full();
    int c, nb, nl;
    @(posedge clk_sys_in);
    {range_wc_in, slow} <= 2'b11;
    b  = mem.n_beats;
    nb = mem.n_burst;
    nl = mem.n_last;
    for (c = 0; c < 8; c++)
      req(1'b1, 32'h2000 + 32'(c * 8), 64'hF00D000000000000 + 64'(c), 8'hFF,
          MT_OVERRIDABLE_UNCACHED);
    wait_beats(b + 8);
    chk("wc_burst_cnt", mem.n_burst, nb + 8);
    chk("wc_burst_only", mem.n_beats, b + 8);
    chk("wc_burst_last", mem.n_last, nl + 1);
    @(posedge clk_sys_in);
    {range_wc_in, slow} <= 2'b00;
  endtask : sc_wc_full
  task automatic sc_reset();
    b = mem.n_beats;
    req(1'b1, 32'h3000, 64'h0123456789ABCDEF, 8'h01, MT_WRITE_COMBINING);
    @(posedge clk_sys_in);
    srst_in <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    {srst_in, serialize_in} <= 2'b01;
    @(posedge clk_sys_in);
    serialize_in <= 1'b0;
    repeat (20) @(negedge clk_sys_in);
    chk("wc_reset_drop", mem.n_beats, b);
  endtask : sc_reset
  // ==========================================================
  // clock and main sequence
  initial
  begin
    clk_sys_in = 1'b0;
    forever #10 clk_sys_in = ~clk_sys_in;
  end
  initial
  begin
    {srst_in, req_valid_in, req_write_in, req_spec_in, range_wc_in} = 5'b10000;
    {serialize_in, slow, req_addr_in, req_wdata_in, req_be_in, req_mtype_in} = '0;
    repeat (4) @(posedge clk_sys_in);
    srst_in <= 1'b0;
    sc_wb();
    sc_wt_wp();
    sc_uc(MT_STRONG_UNCACHED);
    sc_uc(MT_OVERRIDABLE_UNCACHED);
    sc_wc_part();
    sc_wc_full();
    sc_reset();
    close_out();
  end
endmodule : tb
